// ---- src/afps_pkg.sv ----
package afps_pkg;

	// ********************************************************************
	// Timing
	// ********************************************************************
	localparam int unsigned AFPS_CLK_HZ = 20_000_000;
	localparam int unsigned AFPS_RESTART_MS = 100;
	localparam int unsigned AFPS_RESTART_CYC = AFPS_RESTART_MS * (AFPS_CLK_HZ / 1000);
	localparam int unsigned AFPS_TMR_W = 21;
	localparam int unsigned AFPS_OC_LIMIT_MA = 6000;

	// ********************************************************************
	// Register map
	// ********************************************************************
	localparam int unsigned AFPS_ADDR_W = 4;
	localparam logic [3:0] AFPS_REG_CTRL = 4'h0;
	localparam logic [3:0] AFPS_REG_STATUS = 4'h4;
	localparam logic [3:0] AFPS_REG_EVENTS = 4'h8;
	localparam logic [3:0] AFPS_REG_LIMIT = 4'hC;

	localparam int unsigned AFPS_CTRL_RUN_BIT = 0;
	localparam logic AFPS_CTRL_RUN_RST = 1'b1;

	localparam int unsigned AFPS_ST_STATE_LSB = 0;
	localparam int unsigned AFPS_ST_STAGE_BIT = 3;
	localparam int unsigned AFPS_ST_FAULT_LSB = 4;
	localparam int unsigned AFPS_ST_FAULT_W = 5;

	localparam int unsigned AFPS_EV_LIMIT = 0;
	localparam int unsigned AFPS_EV_OC_SHUT = 1;
	localparam int unsigned AFPS_EV_SUPPLY = 2;
	localparam int unsigned AFPS_EV_THERM = 3;
	localparam int unsigned AFPS_EV_WINDOW = 4;
	localparam int unsigned AFPS_EV_W = 5;

	// ********************************************************************
	// Sequencer states
	// ********************************************************************
	typedef enum logic [2:0] {
		AFPS_STANDBY = 3'b000,
		AFPS_WINDOW = 3'b001,
		AFPS_DELAY = 3'b010,
		AFPS_RUN = 3'b011,
		AFPS_OC_WAIT = 3'b100,
		AFPS_FAULT = 3'b101
	} afps_state_t;

endpackage : afps_pkg

// ---- src/afps_seq.sv ----
// Functional notes
// R1: Each output switch has its own overcurrent flag and any of them raises a limit event.
// R2: Above the impedance threshold the stage only limits current and both outputs keep switching.
// R3: A trip turns the conducting switch off and its partner on until the next switching cycle.
// R4: While limiting a low-impedance short the capacitor sink is on, and it releases when switching resumes.
// R5: A fully discharged timing capacitor shuts the amplifier down and starts the restart timer.
// R6: After an overcurrent shutdown a restart is tried every 100 ms and fails again while overcurrent persists.
// R7: Once overcurrent is gone the next restart succeeds and the amplifier stays running.
// R8: Leaving standby, every output is checked for a supply short before the stages are enabled.
// R9: A supply short holds start-up until it clears, then the sequence continues at once.
// R10: The supply short check is repeated on every overcurrent restart attempt.
// R11: Under-voltage shuts down and the system restarts 100 ms after it clears.
// R12: Over-voltage disables the stages and the system restarts 100 ms after it clears.
// R13: Either supply above twice the other is an unbalance fault with a 100 ms restart after it clears.
// R14: Over-temperature shuts down and switching resumes 100 ms after it clears.
// R15: After leaving standby the outputs wait 100 ms before switching starts.
// R16: Stages run only with no shutdown fault and no restart delay pending, and faults combine by OR.
`timescale 1ns/1ns
`default_nettype none

module afps_seq
	import afps_pkg::*;
#(
	parameter int unsigned NCH = 2,
	parameter int unsigned RESTART_CYCLES = AFPS_RESTART_CYC
) (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic [AFPS_ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic mode_on,
	input wire logic mode_op,
	input wire logic [NCH-1:0] oc_hi,
	input wire logic [NCH-1:0] oc_lo,
	input wire logic [NCH-1:0] low_z,
	input wire logic cap_empty,
	input wire logic uv_flag,
	input wire logic ov_flag,
	input wire logic ub_pos,
	input wire logic ub_neg,
	input wire logic ot_flag,
	input wire logic wp_short,
	input wire logic [NCH-1:0] pwm_in,
	input wire logic cycle_start,
	output logic [NCH-1:0] hi_on,
	output logic [NCH-1:0] lo_on,
	output logic cap_sink_en,
	output logic stage_en,
	output logic demute
);

	localparam int unsigned NA = 9 + 3 * NCH;
	localparam int unsigned B = 2 + 3 * NCH;
	localparam logic [AFPS_TMR_W-1:0] TMR_MAX = AFPS_TMR_W'(RESTART_CYCLES - 1);

	if (NCH < 1 || RESTART_CYCLES < 1 || RESTART_CYCLES > (1 << AFPS_TMR_W)) begin : g_bad_param
		$error("afps_seq: unsupported NCH or RESTART_CYCLES");
	end

	// ********************************************************************
	// Reset release and pin synchronisers
	// ********************************************************************
	logic [1:0] rst_sync_q;
	logic rst_n;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	logic [NA-1:0] pins_in;
	logic [NA-1:0] sync1_q;
	logic [NA-1:0] sync2_q;
	logic [NA-1:0] sync3_q;
	logic [NA-1:0] filt_q;

	assign pins_in = {wp_short, ot_flag, ub_neg, ub_pos, ov_flag, uv_flag, cap_empty, low_z, oc_lo, oc_hi, mode_op,
		mode_on};

	// A pin change is taken only once the second and third stages agree, so a
	// level caught mid-transition never reaches the sequencer.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_q <= '0;
			sync2_q <= '0;
			sync3_q <= '0;
			filt_q <= '0;
		end else begin
			sync1_q <= pins_in;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			filt_q <= (filt_q & (sync2_q ^ sync3_q)) | (sync2_q & ~(sync2_q ^ sync3_q));
		end
	end

	logic mode_on_s;
	logic mode_op_s;
	logic [NCH-1:0] oc_hi_s;
	logic [NCH-1:0] oc_lo_s;
	logic [NCH-1:0] low_z_s;
	logic cap_s;
	logic uv_s;
	logic ov_s;
	logic ub_s;
	logic ot_s;
	logic wp_s;
	logic fault_any;

	assign mode_on_s = filt_q[0];
	assign mode_op_s = filt_q[1];
	assign oc_hi_s = filt_q[2 +: NCH];
	assign oc_lo_s = filt_q[2+NCH +: NCH];
	assign low_z_s = filt_q[2+2*NCH +: NCH];
	assign cap_s = filt_q[B];
	assign uv_s = filt_q[B+1];
	assign ov_s = filt_q[B+2];
	assign ub_s = filt_q[B+3] | filt_q[B+4]; // see R13
	assign ot_s = filt_q[B+5];
	assign wp_s = filt_q[B+6];
	assign fault_any = uv_s | ov_s | ub_s | ot_s; // see R14 R16

	// ********************************************************************
	// Registers
	// ********************************************************************
	logic ctrl_run_q;
	logic [AFPS_EV_W-1:0] ev_q;
	logic [AFPS_EV_W-1:0] ev_set;
	logic [AFPS_EV_W-1:0] ev_clr;
	logic [31:0] rdata_q;
	afps_state_t state_q;
	afps_state_t state_d;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_run_q <= AFPS_CTRL_RUN_RST;
		end else if (reg_wr && reg_addr == AFPS_REG_CTRL) begin
			ctrl_run_q <= reg_wdata[AFPS_CTRL_RUN_BIT];
		end
	end

	assign ev_clr = (reg_wr && reg_addr == AFPS_REG_EVENTS) ? reg_wdata[AFPS_EV_W-1:0] : '0;

	// Write-one-to-clear; an event in the clearing cycle survives.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ev_q <= '0;
		end else begin
			ev_q <= (ev_q & ~ev_clr) | ev_set;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= 32'h0000_0000;
		end else begin
			rdata_q <= 32'h0000_0000;
			if (reg_rd) begin
				unique case (reg_addr)
					AFPS_REG_CTRL: rdata_q[AFPS_CTRL_RUN_BIT] <= ctrl_run_q;
					AFPS_REG_STATUS: begin
						rdata_q[AFPS_ST_STATE_LSB +: 3] <= state_q;
						rdata_q[AFPS_ST_STAGE_BIT] <= stage_en;
						rdata_q[AFPS_ST_FAULT_LSB +: AFPS_ST_FAULT_W] <= {wp_s, ot_s, ub_s, ov_s, uv_s};
					end
					AFPS_REG_EVENTS: rdata_q[AFPS_EV_W-1:0] <= ev_q;
					AFPS_REG_LIMIT: rdata_q <= AFPS_OC_LIMIT_MA;
					default: rdata_q <= 32'h0000_0000;
				endcase
			end
		end
	end
	assign reg_rdata = rdata_q;

	// ********************************************************************
	// Start-up and restart sequencer
	// ********************************************************************
	logic [AFPS_TMR_W-1:0] tmr_q;
	logic tmr_load;
	logic retry_q;
	logic enable_req;
	logic go_ok;

	assign enable_req = mode_on_s & ctrl_run_q;
	assign go_ok = enable_req & ~fault_any;

	always_comb begin
		state_d = state_q;
		tmr_load = 1'b0;
		unique case (state_q)
			AFPS_STANDBY: state_d = AFPS_WINDOW;
			AFPS_WINDOW: begin
				if (!wp_s) begin // see R8
					if (retry_q) begin
						state_d = AFPS_RUN; // see R7 R9
					end else begin
						state_d = AFPS_DELAY; // see R15
						tmr_load = 1'b1;
					end
				end
			end
			AFPS_DELAY: begin
				if (tmr_q == '0) begin
					state_d = AFPS_RUN;
				end
			end
			AFPS_RUN: begin
				if (cap_s) begin // see R5
					state_d = AFPS_OC_WAIT;
					tmr_load = 1'b1;
				end
			end
			AFPS_OC_WAIT: begin
				if (tmr_q == '0) begin
					state_d = AFPS_WINDOW; // see R6
				end
			end
			AFPS_FAULT: begin
				if (!fault_any) begin
					state_d = AFPS_DELAY; // see R11
					tmr_load = 1'b1;
				end
			end
			default: state_d = AFPS_STANDBY;
		endcase
		if (fault_any) begin // see R12
			state_d = AFPS_FAULT;
			tmr_load = 1'b0;
		end
		if (!enable_req) begin
			state_d = AFPS_STANDBY;
			tmr_load = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= AFPS_STANDBY;
		end else begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tmr_q <= '0;
		end else if (tmr_load) begin
			tmr_q <= TMR_MAX;
		end else if (tmr_q != '0) begin
			tmr_q <= tmr_q - 1'b1;
		end
	end

	// A window check after an overcurrent shutdown leads straight back to run.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			retry_q <= 1'b0;
		end else if (state_d == AFPS_OC_WAIT) begin
			retry_q <= 1'b1; // see R10
		end else if (state_d == AFPS_STANDBY || state_d == AFPS_FAULT) begin
			retry_q <= 1'b0;
		end
	end

	assign stage_en = (state_q == AFPS_RUN); // see R16

	// ********************************************************************
	// Cycle-by-cycle current limiting
	// ********************************************************************
	logic [NCH-1:0] trip;
	logic [NCH-1:0] lim_q;
	logic [NCH-1:0] lim_lo_q;
	logic [NCH-1:0] hi_q;
	logic [NCH-1:0] lo_q;
	logic sink_q;
	logic demute_q;

	assign trip = (hi_q & oc_hi_s) | (lo_q & oc_lo_s); // see R1

	// A trip in the same cycle as a cycle start keeps the limit for one more period.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			lim_q <= '0;
			lim_lo_q <= '0;
		end else if (!stage_en) begin
			lim_q <= '0;
			lim_lo_q <= '0;
		end else begin
			lim_q <= trip | (lim_q & ~{NCH{cycle_start}}); // see R3
			lim_lo_q <= (trip & hi_q) | (~trip & lim_lo_q);
		end
	end

	// Limiting never stops the switching by itself, so a high-impedance overload
	// only clips.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			hi_q <= '0;
			lo_q <= '0;
		end else if (!stage_en) begin
			hi_q <= '0;
			lo_q <= '0;
		end else begin
			hi_q <= (lim_q & ~lim_lo_q) | (~lim_q & pwm_in); // see R2
			lo_q <= (lim_q & lim_lo_q) | (~lim_q & ~pwm_in); // see R3
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sink_q <= 1'b0;
			demute_q <= 1'b0;
		end else begin
			sink_q <= stage_en & (|(lim_q & low_z_s)); // see R4
			demute_q <= stage_en & mode_op_s;
		end
	end

	assign hi_on = hi_q;
	assign lo_on = lo_q;
	assign cap_sink_en = sink_q;
	assign demute = demute_q;

	assign ev_set[AFPS_EV_LIMIT] = stage_en & (|trip);
	assign ev_set[AFPS_EV_OC_SHUT] = stage_en & cap_s;
	assign ev_set[AFPS_EV_SUPPLY] = uv_s | ov_s | ub_s;
	assign ev_set[AFPS_EV_THERM] = ot_s; // see R14
	assign ev_set[AFPS_EV_WINDOW] = (state_q == AFPS_WINDOW) & wp_s;

	// ********************************************************************
	// Assertions
	// ********************************************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	limit_trip_a: assert property ( // see R1
		stage_en && trip[0] ##1 stage_en |-> lim_q[0] ##1 (hi_q[0] != lo_q[0]))
		else $error("trip did not start limiting");
	oc_comp_a: assert property ( // see R3
		stage_en && lim_q[0] |=> lo_q[0] == $past(lim_lo_q[0]) && hi_q[0] == !$past(lim_lo_q[0]))
		else $error("limit did not drive the complementary switch");
	cycle_clear_a: assert property ( // see R3
		stage_en && cycle_start && !trip[0] |=> !lim_q[0])
		else $error("limit not released at cycle start");
	clip_only_a: assert property ( // see R2
		stage_en && !cap_s && go_ok |=> stage_en)
		else $error("limiting stopped the stages");
	sink_on_a: assert property ( // see R4
		stage_en && lim_q[0] && low_z_s[0] |=> cap_sink_en)
		else $error("sink not enabled on low impedance limit");
	oc_shut_a: assert property ( // see R5
		stage_en && cap_s && go_ok |=> state_q == AFPS_OC_WAIT && tmr_q == TMR_MAX && !stage_en)
		else $error("empty capacitor did not shut down");
	retry_time_a: assert property ( // see R6
		state_q == AFPS_OC_WAIT && tmr_q == '0 && go_ok |=> state_q == AFPS_WINDOW)
		else $error("restart attempt missed");
	wp_hold_a: assert property ( // see R9
		state_q == AFPS_WINDOW && wp_s && go_ok |=> state_q == AFPS_WINDOW && !stage_en)
		else $error("start-up not held by supply short");
	wp_retry_a: assert property ( // see R7
		state_q == AFPS_WINDOW && !wp_s && retry_q && go_ok |=> stage_en)
		else $error("clean restart did not resume");
	fault_off_a: assert property ( // see R16
		fault_any && state_q != AFPS_STANDBY |=> !stage_en ##0 (state_q == AFPS_FAULT || state_q == AFPS_STANDBY))
		else $error("fault did not stop the stages");
	fault_wait_a: assert property ( // see R11
		state_q == AFPS_FAULT && go_ok |=> state_q == AFPS_DELAY && tmr_q == TMR_MAX)
		else $error("fault clear did not start restart delay");
	delay_hold_a: assert property ( // see R15
		state_q == AFPS_DELAY && tmr_q != '0 |=> !stage_en)
		else $error("stages enabled before delay expired");

endmodule : afps_seq

`default_nettype wire

// ---- tb/afps_amp_model.sv ----
`timescale 1ns/1ns
`default_nettype none

module afps_amp_model
	import afps_pkg::*;
(
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic short_en,
	input wire logic short_lz,
	input wire logic short_pos,
	input wire logic [1:0] hi_on,
	input wire logic [1:0] lo_on,
	input wire logic cap_sink_en,
	output logic [1:0] pwm_in,
	output logic cycle_start,
	output logic [1:0] oc_hi,
	output logic [1:0] oc_lo,
	output logic [1:0] low_z,
	output logic cap_empty
);
	// ********************************************************************
	// Switches, detectors and timing capacitor
	// ********************************************************************
	logic [3:0] phase_q;
	logic [3:0] cap_q;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			phase_q <= 4'h0;
		end else begin
			phase_q <= phase_q + 4'h1;
		end
	end

	assign cycle_start = (phase_q == 4'h0);
	assign pwm_in = {phase_q < 4'h6, phase_q < 4'hA};
	// The short sits on channel 0; toward the negative rail its high switch overloads, toward the positive its low one.
	assign oc_hi = {1'b0, short_en & ~short_pos & hi_on[0]};
	assign oc_lo = {1'b0, short_en & short_pos & lo_on[0]};
	assign low_z = {1'b0, short_en & short_lz};

	// The capacitor loses charge only while the sink is on and recovers one step per cycle.
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			cap_q <= 4'hC;
		end else if (cap_sink_en && cap_q != 4'h0) begin
			cap_q <= cap_q - 4'h1;
		end else if (!cap_sink_en && cap_q != 4'hC) begin
			cap_q <= cap_q + 4'h1;
		end
	end

	assign cap_empty = (cap_q == 4'h0);
endmodule : afps_amp_model

`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/1ns
`default_nettype none

module tb
	import afps_pkg::*;
;
	// ********************************************************************
	// Bench
	// ********************************************************************
	logic sys_clk = 1'b0;
	logic arst_n = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic mode_on = 1'b0;
	logic mode_op = 1'b0;
	logic [4:0] flt = 5'h00;
	logic wp_short = 1'b0;
	logic short_en = 1'b0;
	logic short_lz = 1'b0;
	logic short_pos = 1'b0;
	logic [31:0] reg_rdata;
	logic [1:0] pwm_in, oc_hi, oc_lo, low_z, hi_on, lo_on;
	logic cycle_start, cap_empty, cap_sink_en, stage_en, demute;
	int miscompares = 0;
	int samples_checked = 0;
	int cyc = 0;

	always #25 sys_clk = ~sys_clk;

	afps_seq #(.NCH(2), .RESTART_CYCLES(20)) u_dut (.sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mode_on(mode_on),
		.mode_op(mode_op), .oc_hi(oc_hi), .oc_lo(oc_lo), .low_z(low_z), .cap_empty(cap_empty),
		.uv_flag(flt[0]), .ov_flag(flt[1]), .ub_pos(flt[2]), .ub_neg(flt[3]), .ot_flag(flt[4]),
		.wp_short(wp_short), .pwm_in(pwm_in), .cycle_start(cycle_start), .hi_on(hi_on), .lo_on(lo_on),
		.cap_sink_en(cap_sink_en), .stage_en(stage_en), .demute(demute));

	afps_amp_model u_amp (.sys_clk(sys_clk), .arst_n(arst_n), .short_en(short_en), .short_lz(short_lz),
		.short_pos(short_pos), .hi_on(hi_on), .lo_on(lo_on), .cap_sink_en(cap_sink_en), .pwm_in(pwm_in),
		.cycle_start(cycle_start), .oc_hi(oc_hi), .oc_lo(oc_lo), .low_z(low_z), .cap_empty(cap_empty));

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd

	// A bounded wait: lim comes back when stage_en never reached v.
	task automatic wait_se(input logic v, input int lim, output int n);
		n = 0;
		while (stage_en !== v && n < lim) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
	endtask : wait_se

	task automatic t_regs();
		logic [31:0] d;
		rd(AFPS_REG_CTRL, d);
		chk(d, 32'h0000_0001);
		rd(AFPS_REG_LIMIT, d);
		chk(d, AFPS_OC_LIMIT_MA);
		rd(4'h2, d);
		chk(d, 32'h0000_0000);
		rd(AFPS_REG_STATUS, d);
		chk(d[3:0], {1'b0, AFPS_STANDBY});
		$display("test regs done");
	endtask : t_regs

	task automatic t_start();
		logic [31:0] d;
		int n;
		@(posedge sys_clk);
		wp_short <= 1'b1;
		mode_on <= 1'b1;
		mode_op <= 1'b1;
		repeat (40) @(posedge sys_clk);
		#1 chk(stage_en, 1'b0);
		rd(AFPS_REG_STATUS, d);
		chk(d[2:0], AFPS_WINDOW);
		@(posedge sys_clk) wp_short <= 1'b0;
		wait_se(1'b1, 60, n);
		chk(n >= 22 && n <= 32, 1'b1);
		repeat (2) @(posedge sys_clk);
		#1 chk(demute, 1'b1);
		$display("test start done");
	endtask : t_start

	// Pass 0 overloads the high switch, pass 1 the low switch, so both limit directions are forced.
	task automatic t_clip();
		logic [31:0] d;
		logic bad, pw;
		int forced, on_n;
		for (int p = 0; p < 2; p++) begin
			bad = 1'b0;
			pw = 1'b0;
			forced = 0;
			on_n = 0;
			@(posedge sys_clk);
			short_pos <= (p == 1);
			short_en <= 1'b1;
			repeat (64) begin
				@(posedge sys_clk);
				#1 bad |= (hi_on[0] & lo_on[0]) | ~stage_en | cap_sink_en;
				forced += (p == 1) ? int'(hi_on[0] & ~pw) : int'(lo_on[0] & pw);
				on_n += (p == 1) ? int'(lo_on[0]) : int'(hi_on[0]);
				pw = pwm_in[0];
			end
			@(posedge sys_clk);
			short_en <= 1'b0;
			short_pos <= 1'b0;
			chk(bad, 1'b0);
			chk(forced > 0 && on_n > 0, 1'b1);
		end
		rd(AFPS_REG_EVENTS, d);
		chk(d[AFPS_EV_LIMIT], 1'b1);
		$display("test clip done");
	endtask : t_clip

	task automatic t_overcurrent();
		logic [31:0] d;
		int n;
		@(posedge sys_clk);
		short_lz <= 1'b1;
		short_en <= 1'b1;
		n = 0;
		while (cap_sink_en !== 1'b1 && n < 40) begin
			@(posedge sys_clk);
			#1 n++;
		end
		chk(n < 40, 1'b1);
		wait_se(1'b0, 200, n);
		chk(n < 200, 1'b1);
		wait_se(1'b1, 60, n);
		chk(n >= 20 && n <= 30, 1'b1);
		wait_se(1'b0, 200, n);
		chk(n < 200, 1'b1);
		@(posedge sys_clk);
		wp_short <= 1'b1;
		short_en <= 1'b0;
		wait_se(1'b1, 60, n);
		chk(n, 60);
		@(posedge sys_clk) wp_short <= 1'b0;
		wait_se(1'b1, 40, n);
		chk(n < 12, 1'b1);
		wait_se(1'b0, 200, n);
		chk(n, 200);
		rd(AFPS_REG_EVENTS, d);
		chk(d[AFPS_EV_OC_SHUT], 1'b1);
		wr(AFPS_REG_EVENTS, 32'hFFFF_FFFF);
		rd(AFPS_REG_EVENTS, d);
		chk(d, 32'h0000_0000);
		$display("test overcurrent done");
	endtask : t_overcurrent

	task automatic t_faults();
		logic [31:0] d;
		logic [4:0] exp_f;
		int n;
		for (int i = 0; i < 6; i++) begin
			@(posedge sys_clk) flt <= (i == 5) ? 5'h11 : 5'h01 << i;
			wait_se(1'b0, 12, n);
			chk(n < 12, 1'b1);
			rd(AFPS_REG_STATUS, d);
			chk(d[2:0], AFPS_FAULT);
			exp_f = (i == 5) ? 5'h09 : (i == 4) ? 5'h08 : (i >= 2) ? 5'h04 : 5'h01 << i;
			chk(d[AFPS_ST_FAULT_LSB +: AFPS_ST_FAULT_W], exp_f);
			repeat (30) @(posedge sys_clk);
			flt <= (i == 5) ? 5'h10 : 5'h00;
			if (i == 5) begin
				wait_se(1'b1, 60, n);
				chk(n, 60);
				@(posedge sys_clk) flt <= 5'h00;
			end
			wait_se(1'b1, 40, n);
			chk(n >= 22 && n <= 32, 1'b1);
		end
		$display("test faults done");
	endtask : t_faults

	// Clearing the run bit forces standby at once; setting it again replays the whole start-up.
	task automatic t_run();
		logic [31:0] d;
		int n;
		wr(AFPS_REG_CTRL, 32'h0000_0000);
		wait_se(1'b0, 12, n);
		chk(n, 1);
		rd(AFPS_REG_CTRL, d);
		chk(d, 32'h0000_0000);
		rd(AFPS_REG_STATUS, d);
		chk(d[3:0], 4'h0);
		wr(AFPS_REG_CTRL, 32'h0000_0001);
		wait_se(1'b1, 60, n);
		chk(n >= 22 && n <= 32, 1'b1);
		rd(AFPS_REG_CTRL, d);
		chk(d, 32'h0000_0001);
		$display("test run done");
	endtask : t_run

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : wrap_up

	// The longest path through all tests is well under two thousand cycles.
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			wrap_up();
		end
	end

	initial begin
		repeat (20) @(posedge sys_clk);
		arst_n <= 1'b1;
		repeat (4) @(posedge sys_clk);
		t_regs();
		t_start();
		t_clip();
		t_overcurrent();
		t_faults();
		t_run();
		wrap_up();
	end
endmodule : tb

`default_nettype wire
